// ### design/psr_params.svh
// Offsets, field positions, reset values and widths of the split retry block
`ifndef PSR_PARAMS_SVH
`define PSR_PARAMS_SVH

// Register word indices; byte address is four times the index
`define PSR_IDX_STATUS     2'h0
`define PSR_IDX_CTRL       2'h1
`define PSR_IDX_STATE      2'h2

// Status word: descriptor bits 63..32 seen as word bits 31..0
`define PSR_ST_ACTIVE      31
`define PSR_ST_XERR        28
`define PSR_ST_PHASE       27
`define PSR_ST_TOGGLE      25
`define PSR_ST_CERR_HI     24
`define PSR_ST_CERR_LO     23
`define PSR_ST_NAK_HI      22
`define PSR_ST_NAK_LO      19
`define PSR_ST_BYTES_HI    14
`define PSR_ST_BYTES_LO    0

// Control word fields
`define PSR_CT_VALID       0
`define PSR_CT_ISOCH       1
`define PSR_CT_RELOAD_HI   28
`define PSR_CT_RELOAD_LO   25

// State word fields
`define PSR_SW_HOLD        0
`define PSR_SW_RES_HI      3
`define PSR_SW_RES_LO      1
`define PSR_SW_CINIT_HI    5
`define PSR_SW_CINIT_LO    4

// Field widths and reset values
`define PSR_CERR_W         2
`define PSR_NAK_W          4
`define PSR_BYTES_W        15
`define PSR_CERR_RST       2'h0
`define PSR_NAK_RST        4'h0
`define PSR_RELOAD_RST     4'h0
`define PSR_BYTES_RST      15'h0000
`define PSR_WORD_RST       32'h0000_0000

`endif

// ### design/psr_pkg.sv
// Types shared by the split retry block
package psr_pkg;

  // Outcome of one split transaction as reported by the transaction engine
  typedef enum logic [2:0] {
    PSR_RES_ACK     = 3'h0,
    PSR_RES_NAK     = 3'h1,
    PSR_RES_NYET    = 3'h2,
    PSR_RES_NORESP  = 3'h3,
    PSR_RES_BADRESP = 3'h4
  } psr_result_t;

endpackage

// ### design/psr_avalon_slave.sv
// Avalon-MM slave front end: one wait state, registered read data
`timescale 1ns/1ps
`default_nettype none
`include "psr_params.svh"

module psr_avalon_slave (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [1:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [31:0] statusWord,
  input  wire logic [31:0] ctrlWord,
  input  wire logic [31:0] stateWord,
  output logic             wrStatus,
  output logic             wrCtrl,
  output logic      [31:0] wrMask
);

  logic        accept;
  logic        hitStatus;
  logic        hitCtrl;
  logic        hitState;
  logic [31:0] next_readdata;

  // Accept at the edge where the master sees waitrequest low
  assign accept    = (avs_read | avs_write) & ~avs_waitrequest;
  assign hitStatus = (avs_address == `PSR_IDX_STATUS);
  assign hitCtrl   = (avs_address == `PSR_IDX_CTRL);
  assign hitState  = (avs_address == `PSR_IDX_STATE);
  assign wrStatus  = accept & avs_write & hitStatus;
  assign wrCtrl    = accept & avs_write & hitCtrl;
  assign wrMask    = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                      {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  // Unmapped addresses read as zero and ignore writes
  assign next_readdata = hitStatus ? statusWord :
                         hitCtrl   ? ctrlWord   :
                         hitState  ? stateWord  : `PSR_WORD_RST;

  // Waitrequest drops for one cycle per request, so every access costs two edges
  always_ff @(posedge mclk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= `PSR_WORD_RST;
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
      if ((avs_read | avs_write) & avs_waitrequest) begin
        avs_readdata <= next_readdata;
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_wait_one_cycle: assert property ((avs_read | avs_write) && avs_waitrequest
                                     |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("waitrequest did not drop for exactly one cycle");
  a_idle_waits: assert property (!avs_read && !avs_write |=> avs_waitrequest)
    else $error("waitrequest low without a request");

endmodule
`default_nettype wire

// ### design/psr_counter_step.sv
// Next values of the split error counter and the NAK counter for one outcome
`timescale 1ns/1ps
`default_nettype none
`include "psr_params.svh"

module psr_counter_step
  import psr_pkg::*;
(
  input  wire logic        [`PSR_CERR_W-1:0] cerr,
  input  wire logic        [`PSR_CERR_W-1:0] cerrInit,
  input  wire logic        [`PSR_NAK_W-1:0]  nak,
  input  wire logic        [`PSR_NAK_W-1:0]  reload,
  input  wire logic                          isoch,
  input  wire psr_pkg::psr_result_t          result,
  output logic             [`PSR_CERR_W-1:0] next_cerr,
  output logic             [`PSR_NAK_W-1:0]  next_nak,
  output logic                               cerrExpired,
  output logic                               nakExpired
);

  logic isError;
  logic isNakLike;
  logic nakArmed;

  // No response or a bad response counts as an error
  assign isError   = (result == PSR_RES_NORESP) | (result == PSR_RES_BADRESP);
  assign isNakLike = (result == PSR_RES_NAK) | (result == PSR_RES_NYET);
  // Reload of zero or an isochronous split leaves the NAK counter alone
  assign nakArmed  = (result == PSR_RES_NAK) & (reload != `PSR_RELOAD_RST) & ~isoch; // RULE10 RULE13

  // Error counter stops at zero rather than wrapping
  assign next_cerr = isNakLike ? cerrInit : // RULE7
                     (isError && cerr != `PSR_CERR_RST) ? cerr - 2'h1 : cerr; // RULE6
  assign cerrExpired = isError & (cerr <= 2'h1); // RULE6

  assign next_nak   = (nakArmed && nak != `PSR_NAK_RST) ? nak - 4'h1 : nak; // RULE9
  assign nakExpired = nakArmed & (nak <= 4'h1); // RULE9

endmodule
`default_nettype wire

// ### design/psr_split_retry.sv
// Status and retry engine of a bulk start/complete split transfer descriptor
// Function
// RULE1: Transaction error flag follows error outcome
// RULE2: Software clears error flag before scheduling
// RULE3: Phase flag: 0 start split, 1 complete
// RULE4: Software loads toggle; hardware writes it back
// RULE5: Two-bit error counter for split transactions
// RULE6: Errors decrement counter; zero clears valid
// RULE7: NAK or NYET restores error counter
// RULE8: Starved retry keeps the descriptor pointer
// RULE9: NAKs decrement counter; zero clears valid
// RULE10: No NAK counting for isochronous splits
// RULE11: Byte count written with bytes moved
// RULE12: Software sets active equal to valid
// RULE13: Zero reload disables NAK counting entirely
`timescale 1ns/1ps
`default_nettype none
`include "psr_params.svh"

module psr_split_retry
  import psr_pkg::*;
#(
  parameter int BYTES_W = `PSR_BYTES_W
) (
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire logic [1:0]            avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [3:0]            avs_byteenable,
  input  wire logic [31:0]           avs_writedata,
  output logic      [31:0]           avs_readdata,
  output logic                       avs_waitrequest,
  input  wire logic                  xferDone,
  input  wire psr_pkg::psr_result_t  xferResult,
  input  wire logic [BYTES_W-1:0]    xferBytes,
  input  wire logic                  xferToggle,
  input  wire logic                  frameStart,
  input  wire logic                  lackTime,
  output logic                       descValid,
  output logic                       descActive,
  output logic                       splitPhase,
  output logic                       holdPointer
);
  import psr_pkg::*;

  // The byte count field is fixed by the descriptor layout
  if (BYTES_W != `PSR_BYTES_W) begin : g_bad_width
    $error("BYTES_W must match the byte count field width");
  end

  logic                    xactErr;
  logic                    dataToggle;
  logic [`PSR_CERR_W-1:0]  cerr;
  logic [`PSR_CERR_W-1:0]  cerrInit;
  logic [`PSR_NAK_W-1:0]   nakRetryCount;
  logic [`PSR_NAK_W-1:0]   nakRestartValue;
  logic                    isoch;
  logic [BYTES_W-1:0]      byteCountDone;
  psr_result_t             lastResult;
  logic                    retryPending;

  logic                    wrStatus;
  logic                    wrCtrl;
  logic [31:0]             wrMask;
  logic [31:0]             statusWord;
  logic [31:0]             ctrlWord;
  logic [31:0]             stateWord;
  logic [31:0]             newStatus;
  logic [31:0]             newCtrl;

  logic                    live;
  logic                    evAck;
  logic                    evNyet;
  logic                    evError;
  logic [`PSR_CERR_W-1:0]  next_cerr;
  logic [`PSR_NAK_W-1:0]   next_nak;
  logic                    cerrExpired;
  logic                    nakExpired;
  logic                    finish;
  logic                    retire;

  // Register views; halt and babble bits are not held here and read zero
  assign statusWord = {descActive, 2'b00, xactErr, splitPhase, 1'b0, dataToggle, cerr,
                       nakRetryCount, 4'h0, byteCountDone};
  assign ctrlWord   = {3'b000, nakRestartValue, 23'h000000, isoch, descValid};
  assign stateWord  = {26'h0000000, cerrInit, lastResult, holdPointer};
  assign newStatus  = (avs_writedata & wrMask) | (statusWord & ~wrMask);
  assign newCtrl    = (avs_writedata & wrMask) | (ctrlWord & ~wrMask);

  psr_avalon_slave u_slave (
    .mclk            (mclk),
    .rst             (rst),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_byteenable  (avs_byteenable),
    .avs_writedata   (avs_writedata),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .statusWord      (statusWord),
    .ctrlWord        (ctrlWord),
    .stateWord       (stateWord),
    .wrStatus        (wrStatus),
    .wrCtrl          (wrCtrl),
    .wrMask          (wrMask)
  );

  psr_counter_step u_step (
    .cerr        (cerr),
    .cerrInit    (cerrInit),
    .nak         (nakRetryCount),
    .reload      (nakRestartValue),
    .isoch       (isoch),
    .result      (xferResult),
    .next_cerr   (next_cerr),
    .next_nak    (next_nak),
    .cerrExpired (cerrExpired),
    .nakExpired  (nakExpired)
  );

  // Outcomes only count while the descriptor is scheduled
  assign live    = xferDone & descValid & descActive;
  assign evAck   = live & (xferResult == PSR_RES_ACK);
  assign evNyet  = live & (xferResult == PSR_RES_NYET);
  assign evError = live & ((xferResult == PSR_RES_NORESP) | (xferResult == PSR_RES_BADRESP));
  // An acknowledged complete split ends the descriptor
  assign finish  = evAck & splitPhase;
  assign retire  = live & (cerrExpired | nakExpired | finish); // RULE6 RULE9 RULE12

  // Descriptor status fields; an outcome in the same cycle as a software
  // write wins, so a hardware update is never lost to a stale write
  always_ff @(posedge mclk) begin
    if (rst) begin
      xactErr       <= 1'b0;
      splitPhase    <= 1'b0;
      dataToggle    <= 1'b0;
      cerr          <= `PSR_CERR_RST;
      nakRetryCount <= `PSR_NAK_RST;
      byteCountDone <= `PSR_BYTES_RST;
    end else if (live) begin
      xactErr       <= xactErr | evError; // RULE1
      cerr          <= next_cerr; // RULE5
      nakRetryCount <= next_nak; // RULE9
      if (evAck) begin
        splitPhase    <= ~splitPhase; // RULE3
        dataToggle    <= splitPhase ? xferToggle : dataToggle; // RULE4
        byteCountDone <= xferBytes; // RULE11
      end
      if (evNyet) begin
        splitPhase <= 1'b1; // RULE3
      end
    end else if (wrStatus) begin
      xactErr       <= newStatus[`PSR_ST_XERR]; // RULE2
      splitPhase    <= newStatus[`PSR_ST_PHASE]; // RULE3
      dataToggle    <= newStatus[`PSR_ST_TOGGLE]; // RULE4
      cerr          <= newStatus[`PSR_ST_CERR_HI:`PSR_ST_CERR_LO];
      nakRetryCount <= newStatus[`PSR_ST_NAK_HI:`PSR_ST_NAK_LO];
      byteCountDone <= newStatus[`PSR_ST_BYTES_HI:`PSR_ST_BYTES_LO];
    end
  end

  // Software's error count is kept as the value a NAK or NYET restores
  always_ff @(posedge mclk) begin
    if (rst) begin
      cerrInit <= `PSR_CERR_RST;
    end else if (wrStatus && !live) begin
      cerrInit <= newStatus[`PSR_ST_CERR_HI:`PSR_ST_CERR_LO]; // RULE7
    end
  end

  // Valid and active: software schedules, hardware retires
  always_ff @(posedge mclk) begin
    if (rst) begin
      descValid  <= 1'b0;
      descActive <= 1'b0;
    end else if (retire) begin
      descValid  <= 1'b0;
      descActive <= 1'b0;
    end else begin
      if (wrCtrl) begin
        descValid <= newCtrl[`PSR_CT_VALID];
      end
      if (wrStatus) begin
        descActive <= newStatus[`PSR_ST_ACTIVE]; // RULE12
      end
    end
  end

  // Control fields other than valid
  always_ff @(posedge mclk) begin
    if (rst) begin
      nakRestartValue <= `PSR_RELOAD_RST;
      isoch           <= 1'b0;
    end else if (wrCtrl) begin
      nakRestartValue <= newCtrl[`PSR_CT_RELOAD_HI:`PSR_CT_RELOAD_LO]; // RULE13
      isoch           <= newCtrl[`PSR_CT_ISOCH]; // RULE10
    end
  end

  // A retry is pending after any non-final outcome that left it scheduled
  always_ff @(posedge mclk) begin
    if (rst) begin
      lastResult   <= PSR_RES_ACK;
      retryPending <= 1'b0;
    end else if (live) begin
      lastResult   <= xferResult;
      retryPending <= ~retire;
    end else if (!descValid) begin
      retryPending <= 1'b0;
    end
  end

  // At a new frame a starved retry holds the aperiodic pointer; the hold
  // lasts until the next frame start so the scheduler sees it all frame
  always_ff @(posedge mclk) begin
    if (rst) begin
      holdPointer <= 1'b0;
    end else if (frameStart) begin
      holdPointer <= retryPending & lackTime & descValid; // RULE8
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_xerr_sets: assert property (evError |=> xactErr) // RULE1
    else $error("error outcome did not set the transaction error flag");
  a_phase_advance: assert property (evAck && !splitPhase |=> splitPhase && descValid) // RULE3
    else $error("acknowledged start split did not move to complete split");
  a_toggle_back: assert property (evAck && splitPhase |=> dataToggle == $past(xferToggle)) // RULE4
    else $error("data toggle not written back");
  a_cerr_decrement: assert property (evError && cerr > 2'h1 |=> cerr == $past(cerr) - 2'h1
                                     && descValid) // RULE5
    else $error("error counter did not decrement");
  a_cerr_retire: assert property (evError && cerr <= 2'h1 |=> !descValid && !descActive) // RULE6
    else $error("valid not cleared at error count zero");
  a_cerr_restore: assert property (live && (xferResult == PSR_RES_NAK || evNyet)
                                   |=> cerr == $past(cerrInit)) // RULE7
    else $error("NAK or NYET did not restore the error counter");
  a_hold_frame: assert property (frameStart && retryPending && lackTime && descValid
                                 |=> holdPointer ##1 (holdPointer || $past(frameStart))) // RULE8
    else $error("starved retry did not hold the pointer");
  a_nak_decrement: assert property (live && xferResult == PSR_RES_NAK && !isoch
                                    && nakRestartValue != 4'h0 && nakRetryCount > 4'h1
                                    |=> nakRetryCount == $past(nakRetryCount) - 4'h1) // RULE9
    else $error("NAK counter did not decrement");
  a_nak_retire: assert property (live && xferResult == PSR_RES_NAK && !isoch
                                 && nakRestartValue != 4'h0 && nakRetryCount <= 4'h1
                                 |=> !descValid) // RULE9
    else $error("valid not cleared at NAK count zero");
  a_nak_ignored: assert property (live && xferResult == PSR_RES_NAK
                                  && (isoch || nakRestartValue == 4'h0)
                                  |=> $stable(nakRetryCount) && descValid) // RULE10 RULE13
    else $error("NAK counter moved while disabled");
  a_bytes_written: assert property (evAck |=> byteCountDone == $past(xferBytes)) // RULE11
    else $error("byte count not written");
  a_finish_clears: assert property (evAck && splitPhase |=> !descActive ##1 !descActive
                                    || $past(wrStatus)) // RULE12
    else $error("finished descriptor still active");

  // Retiring drops valid and active together, so the scheduler never finds
  // a descriptor that is still active but no longer valid after a retire
  a_retire_pair: assert property (retire |=> !descValid && !descActive) // RULE12
    else $error("retire left valid or active set");

  // Any outcome that leaves the descriptor scheduled marks a pending retry;
  // the frame logic relies on this mark to decide the pointer hold
  a_retry_marked: assert property (live && !retire |=> retryPending) // RULE8
    else $error("scheduled descriptor not marked as a pending retry");

  // With no outcome and no software write both counters hold; a stray
  // decrement here would retire a descriptor early
  a_counters_hold: assert property (!live && !wrStatus
                                    |=> $stable(cerr) && $stable(nakRetryCount)) // RULE5
    else $error("counter moved with no outcome or write");

  // The toggle stays as loaded until the complete split is acknowledged
  a_start_toggle: assert property (evAck && !splitPhase |=> $stable(dataToggle)) // RULE4
    else $error("start split changed the data toggle");

  // NYET moves the descriptor into complete split
  a_nyet_phase: assert property (evNyet |=> splitPhase) // RULE3
    else $error("NYET did not select complete split");

  // An outcome for an unscheduled descriptor must leave its fields alone
  a_ignored_outcome: assert property (xferDone && !live && !wrStatus
                                      |=> $stable(byteCountDone) && $stable(splitPhase)) // RULE11
    else $error("outcome changed an unscheduled descriptor");

  // The hold is only re-evaluated on a frame mark; between marks the
  // scheduler relies on a steady value
  a_hold_steady: assert property (!frameStart |=> $stable(holdPointer)) // RULE8
    else $error("pointer hold changed between frame marks");

  c_full_split: cover property (evAck && !splitPhase ##[1:50] evAck && splitPhase);
  c_error_retire: cover property (evError && cerr == 2'h1);
  c_nak_retire: cover property (live && nakExpired);
  c_hold: cover property (frameStart && retryPending && lackTime);
  // A NAK on an isochronous split, where the NAK counter stays out of play
  c_isoch_nak: cover property (live && isoch && xferResult == PSR_RES_NAK);

endmodule
`default_nettype wire

// ### bench/psr_hub_model.sv
// Stand-in for the transaction engine and hub: split outcomes and frame marks
`timescale 1ns/1ps
`default_nettype none

module psr_hub_model
  import psr_pkg::*;
(
  input  wire logic                 mclk,
  output var  psr_pkg::psr_result_t xferResult,
  output logic                      xferDone,
  output logic [14:0]               xferBytes,
  output logic                      xferToggle,
  output logic                      frameStart,
  output logic                      lackTime
);

  // Quiet outputs from time zero
  initial begin
    xferDone   = 1'b0;
    xferResult = PSR_RES_ACK;
    xferBytes  = 15'h0000;
    xferToggle = 1'b0;
    frameStart = 1'b0;
    lackTime   = 1'b0;
  end

  // One outcome pulse; fields are inverted afterwards, so a stale no response reads as a bad response and the reverse
  task automatic send(input psr_result_t r, input logic [14:0] b, input logic t);
    xferDone   <= 1'b1;
    xferResult <= r;
    xferBytes  <= b;
    xferToggle <= t;
    @(posedge mclk);
    xferDone   <= 1'b0;
    xferResult <= psr_result_t'(~r);
    xferBytes  <= ~b;
    xferToggle <= ~t;
    @(posedge mclk); // Idle cycle lets the block's updates land
  endtask

  // Frame mark with the time-left indication sampled on it
  task automatic frame(input logic lack);
    frameStart <= 1'b1;
    lackTime   <= lack;
    @(posedge mclk);
    frameStart <= 1'b0;
    lackTime   <= ~lack;
    @(posedge mclk);
  endtask

endmodule

`default_nettype wire

// ### bench/tb_psr_split_retry.sv
// Register-level bench for the split retry block with a hub stand-in
`timescale 1ns/1ps
`default_nettype none
`include "psr_params.svh"

module tb_psr_split_retry;
  import psr_pkg::*;

  localparam logic [31:0] ALL    = 32'hffff_ffff;
  localparam logic [31:0] CERR_M = 32'h0180_0000;
  localparam logic [31:0] BYTE_M = 32'h0000_7fff;

  logic        mclk;
  logic        rst;
  logic [1:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        xferDone;
  psr_result_t xferResult;
  logic [14:0] xferBytes;
  logic        xferToggle;
  logic        frameStart;
  logic        lackTime;
  logic        descValid;
  logic        descActive;
  logic        splitPhase;
  logic        holdPointer;
  int          failCount;
  int          samplesChecked;

  psr_split_retry #(.BYTES_W(15)) uut (
    .mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .xferDone(xferDone),
    .xferResult(xferResult), .xferBytes(xferBytes), .xferToggle(xferToggle),
    .frameStart(frameStart), .lackTime(lackTime), .descValid(descValid),
    .descActive(descActive), .splitPhase(splitPhase), .holdPointer(holdPointer));

  psr_hub_model hub (
    .mclk(mclk), .xferResult(xferResult), .xferDone(xferDone), .xferBytes(xferBytes),
    .xferToggle(xferToggle), .frameStart(frameStart), .lackTime(lackTime));

  // 25 MHz clock
  initial mclk = 1'b0;
  always #20 mclk = ~mclk;

  // Status word image built from its fields
  function automatic logic [31:0] mk(input logic a, input logic x, input logic p,
                                     input logic t, input logic [1:0] c, input logic [3:0] n,
                                     input logic [14:0] b);
    return (32'(a) << `PSR_ST_ACTIVE) | (32'(x) << `PSR_ST_XERR) | (32'(p) << `PSR_ST_PHASE)
         | (32'(t) << `PSR_ST_TOGGLE) | (32'(c) << `PSR_ST_CERR_LO)
         | (32'(n) << `PSR_ST_NAK_LO) | 32'(b);
  endfunction

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    samplesChecked++;
    if (got !== exp) begin
      failCount++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Holds the request until waitrequest is sampled low, then idles one cycle
  task automatic avAccess(input logic wr, input logic [1:0] a, input logic [31:0] d,
                          input logic [3:0] be, output logic [31:0] q);
    int n;
    n = 0;
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_write      <= wr;
    avs_read       <= ~wr;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge mclk);
      n++;
    end
    q = avs_readdata;
    if (n >= 50) check("bus answer", 32'h0, 32'h1);
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic avWrite(input logic [1:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] q;
    avAccess(1'b1, a, d, be, q);
  endtask

  task automatic expRd(input logic [1:0] a, input logic [31:0] m, input logic [31:0] e,
                       input string name);
    logic [31:0] q;
    avAccess(1'b0, a, 32'h0, 4'hf, q);
    check(name, e & m, q & m);
  endtask

  // Software schedules a descriptor: error flag clear, start split, active equals valid
  task automatic setup(input logic [1:0] c, input logic [3:0] n, input logic [3:0] rl,
                       input logic iso);
    avWrite(2'h0, mk(1'b1, 1'b0, 1'b0, 1'b1, c, n, 15'h0), 4'hf);
    avWrite(2'h1, (32'(rl) << 25) | (32'(iso) << 1) | 32'h1, 4'hf);
  endtask

  task automatic chkFlags(input logic v, input logic a);
    check("valid flag", {31'h0, v}, {31'h0, descValid});
    check("active flag", {31'h0, a}, {31'h0, descActive});
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", samplesChecked, failCount);
    if (failCount == 0 && samplesChecked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Watchdog well beyond the expected run of some 130 cycles
  initial begin
    repeat (5000) @(posedge mclk);
    failCount++;
    summarize();
  end

  // Main sequence
  initial begin
    failCount = 0;
    samplesChecked = 0;
    rst <= 1'b1;
    avs_address <= 2'h0;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_byteenable <= 4'hf;
    avs_writedata <= 32'h0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    // Reset values, unmapped and read-only places
    expRd(2'h0, ALL, 32'h0, "status reset");
    expRd(2'h1, ALL, 32'h0, "ctrl reset");
    avWrite(2'h3, ALL, 4'hf);
    avWrite(2'h2, 32'h0000_003f, 4'hf);
    expRd(2'h3, ALL, 32'h0, "unmapped");
    expRd(2'h2, ALL, 32'h0, "state read-only");
    chkFlags(1'b0, 1'b0);
    // Error, NAK and NYET walk on one descriptor
    setup(2'h3, 4'h3, 4'h3, 1'b0);
    expRd(2'h1, ALL, 32'h0600_0001, "ctrl setup");
    chkFlags(1'b1, 1'b1);
    hub.send(PSR_RES_NORESP, 15'h0011, 1'b0);
    expRd(2'h0, ALL, mk(1, 1, 0, 1, 2'h2, 4'h3, 15'h0), "after noresp");
    hub.send(PSR_RES_NAK, 15'h0022, 1'b0);
    expRd(2'h0, ALL, mk(1, 1, 0, 1, 2'h3, 4'h2, 15'h0), "after nak");
    hub.frame(1'b1);
    check("hold pointer", 32'h1, {31'h0, holdPointer});
    expRd(2'h2, ALL, 32'h0000_0033, "state after nak");
    hub.frame(1'b0);
    check("hold released", 32'h0, {31'h0, holdPointer});
    hub.send(PSR_RES_NYET, 15'h0033, 1'b0);
    expRd(2'h0, ALL, mk(1, 1, 1, 1, 2'h3, 4'h2, 15'h0), "after nyet");
    check("phase port", 32'h1, {31'h0, splitPhase});
    hub.send(PSR_RES_NAK, 15'h0044, 1'b0);
    hub.send(PSR_RES_NAK, 15'h0055, 1'b0);
    chkFlags(1'b0, 1'b0);
    hub.send(PSR_RES_ACK, 15'h0066, 1'b0);
    expRd(2'h0, BYTE_M, 32'h0, "ignored when retired");
    hub.frame(1'b1);
    check("no hold when retired", 32'h0, {31'h0, holdPointer});
    // Zero reload leaves the NAK counter alone
    setup(2'h3, 4'h1, 4'h0, 1'b0);
    hub.send(PSR_RES_NAK, 15'h0077, 1'b0);
    expRd(2'h0, ALL, mk(1, 0, 0, 1, 2'h3, 4'h1, 15'h0), "zero reload");
    chkFlags(1'b1, 1'b1);
    // Isochronous split skips NAK counting; byte lanes then clear the flag
    setup(2'h3, 4'h1, 4'h3, 1'b1);
    hub.send(PSR_RES_NAK, 15'h0088, 1'b0);
    expRd(2'h0, ALL, mk(1, 0, 0, 1, 2'h3, 4'h1, 15'h0), "isoch nak");
    avWrite(2'h1, 32'h0000_0001, 4'h1);
    expRd(2'h1, ALL, 32'h0600_0001, "byte lane write");
    hub.send(PSR_RES_NAK, 15'h0099, 1'b0);
    chkFlags(1'b0, 1'b0);
    // A bad response then no response from a count of two retire the descriptor
    setup(2'h2, 4'h3, 4'h3, 1'b0);
    hub.send(PSR_RES_BADRESP, 15'h00aa, 1'b0);
    expRd(2'h0, ALL, mk(1, 1, 0, 1, 2'h1, 4'h3, 15'h0), "after badresp");
    chkFlags(1'b1, 1'b1);
    hub.send(PSR_RES_NORESP, 15'h00bb, 1'b0);
    chkFlags(1'b0, 1'b0);
    expRd(2'h0, CERR_M, 32'h0, "error count zero");
    // Start split then complete split, both acknowledged
    setup(2'h3, 4'h3, 4'h3, 1'b0);
    hub.send(PSR_RES_ACK, 15'h1234, 1'b0);
    expRd(2'h0, ALL, mk(1, 0, 1, 1, 2'h3, 4'h3, 15'h1234), "start ack");
    hub.send(PSR_RES_ACK, 15'h7fff, 1'b0);
    expRd(2'h0, ALL, mk(0, 0, 0, 0, 2'h3, 4'h3, 15'h7fff), "complete ack");
    chkFlags(1'b0, 1'b0);
    check("phase back", 32'h0, {31'h0, splitPhase});
    summarize();
  end

endmodule

`default_nettype wire
